// File: core/pmbus_status_pkg.sv
// shared constants, field positions and carrier types for the status register bank
package pmbus_status_pkg;
   // read-byte command codes of the four status registers
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7A;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
   localparam logic [7:0] CMD_INPUT_SUPPLY_STATUS = 8'h7C;
   localparam logic [7:0] CMD_VENDOR_SPECIFIC_STATUS = 8'h80;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // output voltage status fields
   localparam int OUTPUT_SENSE_PIN_OV_BIT = 6;
   localparam int OUTPUT_SENSE_PIN_UV_BIT = 5;
   // output current status fields
   localparam int IOUT_FAULT_BIT = 7;
   localparam int IOUT_WARN_BIT = 5;
   // input supply status fields
   localparam int IN_PIN_OV_BIT = 7;
   localparam int IN_MON_OV_BIT = 6;
   localparam int IN_MON_UV_BIT = 5;
   localparam int IN_PIN_UV_BIT = 4;
   // vendor specific status fields
   localparam int SHORT_BIT = 7;
   localparam int LOW_LIVE_BIT = 6;
   localparam int HIGH_LIVE_BIT = 5;
   localparam int LIMIT_BIT = 3;
   localparam int REASON_LSB = 1;
   localparam int WARN2_BIT = 0;
   // summary nibble positions (summary word bits 15..12)
   localparam int SUMMARY_OUTPUT_SENSE_PIN = 3;
   localparam int SUMMARY_IOUT = 2;
   localparam int SUMMARY_INPUT = 1;
   localparam int SUMMARY_VENDOR = 0;
   localparam logic [3:0] SUMMARY_RESET = 4'h0;

   typedef enum logic [1:0] {
      REASON_NONE = 2'h0,
      REASON_OVERCURRENT = 2'h1,
      REASON_UNDERVOLT = 2'h2,
      REASON_OVERVOLT = 2'h3
   } turnoff_reason_t;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'h1,
      LINK_WAIT = 2'h2
   } link_state_t;

   typedef struct packed {
      logic output_sense_pin_ov;
      logic output_sense_pin_uv;
      logic iout_warn;
      logic vin_ov;
      logic vin_uv;
      logic current_above_second;
      logic current_below_second;
   } monitor_events_t;

   typedef struct packed {
      logic oc_fault_shutdown;
      logic current_limiting;
      logic switch_shorted;
   } hotswap_events_t;

   typedef struct packed {
      logic supported;
      logic [7:0] data;
   } read_answer_t;

   localparam read_answer_t ANSWER_RESET = '{supported: 1'b0, data: 8'h00};
endpackage : pmbus_status_pkg

// File: core/pmbus_status_registers.sv
// status register bank with read-byte request port on the link clock
//
// Summary of operation
// RULE1 - read of code 0x7A returns output voltage status, reset 0x00
// RULE2 - output voltage status exists only when the output sense pin is present
// RULE3 - bit 6 latches on monitor output overvoltage
// RULE4 - bit 5 latches on monitor output undervoltage
// RULE5 - reserved bits of all four registers always read zero
// RULE6 - read of code 0x7B returns output current status, reset 0x00
// RULE7 - current bit 7 latches only after timed overcurrent shut the gate down
// RULE8 - current bit 5 latches when current passes the overcurrent warning limit
// RULE9 - read of code 0x7C returns input status, reset 0x00
// RULE10 - input bit 7 latches on overvoltage pin comparator
// RULE11 - input bit 6 latches on monitor input overvoltage
// RULE12 - input bit 5 latches on monitor input undervoltage
// RULE13 - input bit 4 latches on undervoltage pin comparator
// RULE14 - read of code 0x80 returns vendor status, reset 0x00
// RULE15 - vendor bit 7 latches when the switch looks shorted
// RULE16 - vendor bit 6 is a live copy of the low pin comparator
// RULE17 - vendor bit 5 is a live copy of the high pin comparator
// RULE18 - vendor bit 3 latches at once when current limiting begins
// RULE19 - vendor bits 2:1 latch turnoff reason: none, overcurrent, undervolt, overvolt
// RULE20 - vendor bit 0 latches on second current limit, polarity selectable
// RULE21 - summary bits go high while any bit of their register is set
// RULE22 - latched bits hold until cleared; live bits follow their source
// RULE23 - host reads each register by read-byte with its command code
`timescale 1ns/1ps
module pmbus_status_registers #(
   parameter bit HAS_OUTPUT_SENSE = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pmbus_status_pkg::monitor_events_t monitor_in,
   input wire pmbus_status_pkg::hotswap_events_t hotswap_in,
   input wire logic second_threshold_polarity_in,
   input wire logic undervoltage_pin_in,
   input wire logic overvoltage_pin_in,
   input wire logic clear_status_in,
   output logic [3:0] summary_out,
   input wire logic link_clk_in,
   input wire logic link_rst_n_in,
   input wire logic read_request_in,
   input wire logic [7:0] command_code_in,
   output logic link_busy_out,
   output logic answer_valid_out,
   output pmbus_status_pkg::read_answer_t answer_out
);
   import pmbus_status_pkg::*;

   // RULE22 latched bits hold
   // set wins over a clear in the same cycle so no event is lost
   function automatic logic next_sticky(input logic flag, input logic set, input logic clear);
      next_sticky = set | (flag & ~clear);
   endfunction : next_sticky

   logic low_pin_meta;
   logic low_pin_sync;
   logic high_pin_meta;
   logic high_pin_sync;
   logic output_sense_pin_ov_flag;
   logic output_sense_pin_uv_flag;
   logic iout_fault_flag;
   logic iout_warn_flag;
   logic in_pin_ov_flag;
   logic in_mon_ov_flag;
   logic in_mon_uv_flag;
   logic in_pin_uv_flag;
   logic shorted_flag;
   logic limit_flag;
   logic warn2_flag;
   logic warn2_event;
   turnoff_reason_t reason;
   logic [7:0] output_sense_pin_byte;
   logic [7:0] iout_byte;
   logic [7:0] input_byte;
   logic [7:0] vendor_byte;
   read_answer_t next_answer;
   read_answer_t answer_hold;
   logic req_meta;
   logic req_sync;
   logic req_seen;
   logic ans_toggle;
   link_state_t link_state;
   logic req_toggle;
   logic [7:0] code_hold;
   logic ans_meta;
   logic ans_sync;
   logic ans_seen;

   // comparators are analog and asynchronous to this clock
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         low_pin_meta <= 1'b0;
         low_pin_sync <= 1'b0;
         high_pin_meta <= 1'b0;
         high_pin_sync <= 1'b0;
      end else begin
         low_pin_meta <= undervoltage_pin_in;
         low_pin_sync <= low_pin_meta;
         high_pin_meta <= overvoltage_pin_in;
         high_pin_sync <= high_pin_meta;
      end
   end

   // RULE3 RULE4 output voltage flags
   // RULE2 never set without the output sense pin
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         output_sense_pin_ov_flag <= 1'b0;
         output_sense_pin_uv_flag <= 1'b0;
      end else begin
         output_sense_pin_ov_flag <= next_sticky(output_sense_pin_ov_flag, monitor_in.output_sense_pin_ov & HAS_OUTPUT_SENSE,
                                     clear_status_in);
         output_sense_pin_uv_flag <= next_sticky(output_sense_pin_uv_flag, monitor_in.output_sense_pin_uv & HAS_OUTPUT_SENSE,
                                     clear_status_in);
      end
   end

   // RULE7 RULE8 output current flags
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         iout_fault_flag <= 1'b0;
         iout_warn_flag <= 1'b0;
      end else begin
         iout_fault_flag <= next_sticky(iout_fault_flag, hotswap_in.oc_fault_shutdown,
                                        clear_status_in);
         iout_warn_flag <= next_sticky(iout_warn_flag, monitor_in.iout_warn, clear_status_in);
      end
   end

   // RULE10 RULE11 RULE12 RULE13 input supply flags
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         in_pin_ov_flag <= 1'b0;
         in_mon_ov_flag <= 1'b0;
         in_mon_uv_flag <= 1'b0;
         in_pin_uv_flag <= 1'b0;
      end else begin
         in_pin_ov_flag <= next_sticky(in_pin_ov_flag, high_pin_sync, clear_status_in);
         in_mon_ov_flag <= next_sticky(in_mon_ov_flag, monitor_in.vin_ov, clear_status_in);
         in_mon_uv_flag <= next_sticky(in_mon_uv_flag, monitor_in.vin_uv, clear_status_in);
         in_pin_uv_flag <= next_sticky(in_pin_uv_flag, low_pin_sync, clear_status_in);
      end
   end

   // RULE20 polarity select: high picks the over condition
   assign warn2_event = second_threshold_polarity_in ? monitor_in.current_above_second
                                                     : monitor_in.current_below_second;

   // RULE15 RULE18 RULE20 vendor latched flags
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         shorted_flag <= 1'b0;
         limit_flag <= 1'b0;
         warn2_flag <= 1'b0;
      end else begin
         shorted_flag <= next_sticky(shorted_flag, hotswap_in.switch_shorted, clear_status_in);
         limit_flag <= next_sticky(limit_flag, hotswap_in.current_limiting, clear_status_in);
         warn2_flag <= next_sticky(warn2_flag, warn2_event, clear_status_in);
      end
   end

   // RULE19 first cause wins; overvolt before undervolt before overcurrent if together
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reason <= REASON_NONE;
      end else if (reason == REASON_NONE || clear_status_in) begin
         if (high_pin_sync) begin
            reason <= REASON_OVERVOLT;
         end else if (low_pin_sync) begin
            reason <= REASON_UNDERVOLT;
         end else if (hotswap_in.oc_fault_shutdown) begin
            reason <= REASON_OVERCURRENT;
         end else begin
            reason <= REASON_NONE;
         end
      end
   end

   // RULE5 reserved positions are tied to zero
   always_comb begin
      output_sense_pin_byte = STATUS_RESET;
      output_sense_pin_byte[OUTPUT_SENSE_PIN_OV_BIT] = output_sense_pin_ov_flag;
      output_sense_pin_byte[OUTPUT_SENSE_PIN_UV_BIT] = output_sense_pin_uv_flag;
      iout_byte = STATUS_RESET;
      iout_byte[IOUT_FAULT_BIT] = iout_fault_flag;
      iout_byte[IOUT_WARN_BIT] = iout_warn_flag;
      input_byte = STATUS_RESET;
      input_byte[IN_PIN_OV_BIT] = in_pin_ov_flag;
      input_byte[IN_MON_OV_BIT] = in_mon_ov_flag;
      input_byte[IN_MON_UV_BIT] = in_mon_uv_flag;
      input_byte[IN_PIN_UV_BIT] = in_pin_uv_flag;
      vendor_byte = STATUS_RESET;
      vendor_byte[SHORT_BIT] = shorted_flag;
      // RULE16 RULE17 live comparator copies
      vendor_byte[LOW_LIVE_BIT] = low_pin_sync;
      vendor_byte[HIGH_LIVE_BIT] = high_pin_sync;
      vendor_byte[LIMIT_BIT] = limit_flag;
      vendor_byte[REASON_LSB +: 2] = reason;
      vendor_byte[WARN2_BIT] = warn2_flag;
   end

   // RULE21 summary nibble
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         summary_out <= SUMMARY_RESET;
      end else begin
         summary_out[SUMMARY_OUTPUT_SENSE_PIN] <= |output_sense_pin_byte;
         summary_out[SUMMARY_IOUT] <= |iout_byte;
         summary_out[SUMMARY_INPUT] <= |input_byte;
         summary_out[SUMMARY_VENDOR] <= |vendor_byte;
      end
   end

   // RULE1 RULE6 RULE9 RULE14 command decode
   always_comb begin
      next_answer = ANSWER_RESET;
      case (code_hold)
         CMD_OUTPUT_VOLTAGE_STATUS: begin
            // RULE2 unsupported on the variant without output sense
            next_answer.supported = HAS_OUTPUT_SENSE;
            next_answer.data = HAS_OUTPUT_SENSE ? output_sense_pin_byte : STATUS_RESET;
         end
         CMD_OUTPUT_CURRENT_STATUS: begin
            next_answer.supported = 1'b1;
            next_answer.data = iout_byte;
         end
         CMD_INPUT_SUPPLY_STATUS: begin
            next_answer.supported = 1'b1;
            next_answer.data = input_byte;
         end
         CMD_VENDOR_SPECIFIC_STATUS: begin
            next_answer.supported = 1'b1;
            next_answer.data = vendor_byte;
         end
         default: begin
            next_answer = ANSWER_RESET;
         end
      endcase
   end

   // core side of the request handshake; code_hold is stable while the toggles differ
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         req_seen <= 1'b0;
         ans_toggle <= 1'b0;
         answer_hold <= ANSWER_RESET;
      end else begin
         req_meta <= req_toggle;
         req_sync <= req_meta;
         req_seen <= req_sync;
         if (req_sync != req_seen) begin
            answer_hold <= next_answer;
            ans_toggle <= ~ans_toggle;
         end
      end
   end

   // link side: one read outstanding at a time, requests while busy are dropped
   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n_in) begin
         link_state <= LINK_IDLE;
         req_toggle <= 1'b0;
         code_hold <= STATUS_RESET;
         ans_meta <= 1'b0;
         ans_sync <= 1'b0;
         ans_seen <= 1'b0;
         link_busy_out <= 1'b0;
         answer_valid_out <= 1'b0;
         answer_out <= ANSWER_RESET;
      end else begin
         ans_meta <= ans_toggle;
         ans_sync <= ans_meta;
         answer_valid_out <= 1'b0;
         case (link_state)
            LINK_IDLE: begin
               // RULE23 one read-byte per command code
               if (read_request_in) begin
                  code_hold <= command_code_in;
                  req_toggle <= ~req_toggle;
                  link_busy_out <= 1'b1;
                  link_state <= LINK_WAIT;
               end
            end
            LINK_WAIT: begin
               if (ans_sync != ans_seen) begin
                  ans_seen <= ans_sync;
                  answer_out <= answer_hold;
                  answer_valid_out <= 1'b1;
                  link_busy_out <= 1'b0;
                  link_state <= LINK_IDLE;
               end
            end
            default: begin
               link_state <= LINK_IDLE;
               link_busy_out <= 1'b0;
            end
         endcase
      end
   end

   a_output_sense_pin_ov_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE3
      (monitor_in.output_sense_pin_ov && HAS_OUTPUT_SENSE) |=> output_sense_pin_ov_flag)
      else $error("output overvoltage flag did not latch");

   a_latched_bit_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE22
      (output_sense_pin_uv_flag && !clear_status_in) |=> output_sense_pin_uv_flag[*3] or ##[0:2] clear_status_in)
      else $error("latched undervoltage flag dropped without a clear");

   a_fault_needs_timer: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
      $rose(iout_fault_flag) |-> $past(hotswap_in.oc_fault_shutdown))
      else $error("overcurrent fault flag rose without timed shutdown");

   a_limit_immediate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE18
      hotswap_in.current_limiting |=> limit_flag)
      else $error("current limiting flag late");

   a_low_pin_live: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE16
      undervoltage_pin_in |-> ##2 vendor_byte[LOW_LIVE_BIT])
      else $error("low comparator copy not high two cycles after pin");

   a_high_pin_live: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE17
      !overvoltage_pin_in |-> ##2 !vendor_byte[HIGH_LIVE_BIT])
      else $error("high comparator copy did not follow pin low");

   a_reason_overvolt: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE19
      (reason == REASON_NONE && high_pin_sync) |=> reason == REASON_OVERVOLT)
      else $error("turnoff reason not recorded as overvoltage");

   a_warn2_polarity: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE20
      (second_threshold_polarity_in && monitor_in.current_above_second) |=> warn2_flag)
      else $error("second current warning missed over condition");

   a_summary_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE21
      output_sense_pin_ov_flag |=> summary_out[SUMMARY_OUTPUT_SENSE_PIN])
      else $error("summary bit missed active voltage status");

   a_reserved_zero: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_in) // RULE5
      (answer_valid_out && code_hold == CMD_OUTPUT_CURRENT_STATUS)
      |-> (answer_out.data & 8'h5F) == 8'h00)
      else $error("reserved current status bits not zero");

   a_variant_support: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_in) // RULE2
      (answer_valid_out && code_hold == CMD_OUTPUT_VOLTAGE_STATUS)
      |-> answer_out.supported == HAS_OUTPUT_SENSE)
      else $error("voltage status support does not match variant");

   a_answer_bound: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_in) // RULE1
      (link_state == LINK_IDLE && read_request_in) |=> ##[2:8] answer_valid_out)
      else $error("read answer not returned in time");
endmodule : pmbus_status_registers

// File: bench/pmbus_host_model.sv
// host model issuing read-byte requests on the link port
`timescale 1ns/1ps
module pmbus_host_model (
   input wire logic link_clk_in,
   input wire logic link_busy_in,
   input wire logic answer_valid_in,
   input wire pmbus_status_pkg::read_answer_t answer_in,
   output logic read_request_out,
   output logic [7:0] command_code_out
);
   import pmbus_status_pkg::*;

   initial begin
      read_request_out = 1'h0;
      command_code_out = 8'hFF;
   end

   task automatic read_byte(input logic [7:0] code, output read_answer_t ans, output bit ok);
      int n;
      ok = 1'b0;
      ans = 'x;
      n = 0;
      @(posedge link_clk_in);
      // only one request outstanding, so wait out a busy port
      while (link_busy_in !== 1'b0 && n < 40) begin
         n++;
         @(posedge link_clk_in);
      end
      read_request_out <= 1'h1;
      command_code_out <= code;
      @(posedge link_clk_in);
      read_request_out <= 1'h0;
      // released code lines show the inverse, never a stale copy
      command_code_out <= ~code;
      n = 0;
      while (!ok && n < 12) begin
         @(posedge link_clk_in);
         n++;
         if (answer_valid_in === 1'b1) begin
            ans = answer_in;
            ok = 1'b1;
         end
      end
   endtask : read_byte
endmodule : pmbus_host_model

// File: bench/pmbus_status_registers_test.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
module pmbus_status_registers_test;
   import pmbus_status_pkg::*;

   logic clk_in, rst_n_in, link_clk_in, link_rst_n_in;
   monitor_events_t monitor;
   hotswap_events_t hotswap;
   logic pol, uv_pin, ov_pin, clear;
   logic [3:0] summary, summary_ns;
   logic req_a, busy_a, valid_a, req_b, busy_b, valid_b;
   logic [7:0] code_a, code_b;
   read_answer_t ans_a, ans_b;
   int err_total, checked;

   logic [6:0] ev_mon [11] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h00, 7'h00, 7'h02, 7'h01,
      7'h00, 7'h02};
   logic [2:0] ev_hs [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0, 3'h0, 3'h4, 3'h0};
   logic [10:0] ev_pol = 11'h2FF;
   logic [7:0] ev_code [11] = '{8'h7A, 8'h7A, 8'h7B, 8'h7C, 8'h7C, 8'h80, 8'h80, 8'h80, 8'h80,
      8'h7B, 8'h80};
   logic [7:0] ev_exp [11] = '{8'h40, 8'h20, 8'h20, 8'h40, 8'h20, 8'h08, 8'h80, 8'h01, 8'h01,
      8'h80, 8'h00};
   logic [7:0] ev_code2 [11] = '{8'h7A, 8'h7A, 8'h7B, 8'h7C, 8'h7C, 8'h7B, 8'h80, 8'h80, 8'h80,
      8'h80, 8'h80};
   logic [7:0] ev_exp2 [11] = '{8'h40, 8'h20, 8'h20, 8'h40, 8'h20, 8'h00, 8'h80, 8'h01, 8'h01,
      8'h02, 8'h00};
   int ev_sum [11] = '{3, 3, 2, 1, 1, 0, 0, 0, 0, 2, 0};
   logic [7:0] codes [4] = '{8'h7A, 8'h7B, 8'h7C, 8'h80};

   pmbus_status_registers #(.HAS_OUTPUT_SENSE(1'b1)) dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .monitor_in(monitor), .hotswap_in(hotswap),
      .second_threshold_polarity_in(pol), .undervoltage_pin_in(uv_pin),
      .overvoltage_pin_in(ov_pin), .clear_status_in(clear), .summary_out(summary),
      .link_clk_in(link_clk_in), .link_rst_n_in(link_rst_n_in), .read_request_in(req_a),
      .command_code_in(code_a), .link_busy_out(busy_a), .answer_valid_out(valid_a),
      .answer_out(ans_a));
   // variant without the output sense pin shares all status inputs
   pmbus_status_registers #(.HAS_OUTPUT_SENSE(1'b0)) dut_nosense_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .monitor_in(monitor), .hotswap_in(hotswap),
      .second_threshold_polarity_in(pol), .undervoltage_pin_in(uv_pin),
      .overvoltage_pin_in(ov_pin), .clear_status_in(clear), .summary_out(summary_ns),
      .link_clk_in(link_clk_in), .link_rst_n_in(link_rst_n_in), .read_request_in(req_b),
      .command_code_in(code_b), .link_busy_out(busy_b), .answer_valid_out(valid_b),
      .answer_out(ans_b));
   pmbus_host_model host_u (.link_clk_in(link_clk_in), .link_busy_in(busy_a),
      .answer_valid_in(valid_a), .answer_in(ans_a), .read_request_out(req_a),
      .command_code_out(code_a));
   pmbus_host_model host_nosense_u (.link_clk_in(link_clk_in), .link_busy_in(busy_b),
      .answer_valid_in(valid_b), .answer_in(ans_b), .read_request_out(req_b),
      .command_code_out(code_b));

   initial begin
      clk_in = 1'h0;
      forever #25 clk_in = ~clk_in;
   end

   // odd offset keeps the link clock out of phase with the core clock
   initial begin
      link_clk_in = 1'h0;
      #37;
      forever #80 link_clk_in = ~link_clk_in;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic rd(input logic sel, input logic [7:0] code, input logic [8:0] exp);
      read_answer_t ans;
      bit ok;
      if (sel) begin
         host_u.read_byte(code, ans, ok);
      end else begin
         host_nosense_u.read_byte(code, ans, ok);
      end
      if (!ok) begin
         err_total++;
         $display("mismatch at %0t: no answer to code %h", $time, code);
         final_report();
      end else begin
         check(ans, exp);
      end
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   task automatic pulse(input logic [6:0] mon, input logic [2:0] hs, input logic p);
      @(posedge clk_in);
      monitor <= mon;
      hotswap <= hs;
      pol <= p;
      @(posedge clk_in);
      monitor <= '0;
      hotswap <= '0;
      cyc(4);
   endtask : pulse

   task automatic clr();
      @(posedge clk_in);
      clear <= 1'h1;
      @(posedge clk_in);
      clear <= 1'h0;
      cyc(4);
   endtask : clr

   initial begin
      rst_n_in = 1'h0;
      link_rst_n_in = 1'h0;
      monitor = '0;
      hotswap = '0;
      pol = 1'h1;
      uv_pin = 1'h0;
      ov_pin = 1'h0;
      clear = 1'h0;
      err_total = 0;
      checked = 0;
      cyc(2);
      rst_n_in <= 1'h1;
      // link side needs edges of its own clock in reset
      repeat (2) @(posedge link_clk_in);
      link_rst_n_in <= 1'h1;
      cyc(2);
      check({5'h0, summary}, 9'h000);
      for (int i = 0; i < 4; i++) begin
         rd(1'b1, codes[i], {1'b1, STATUS_RESET});
      end
      rd(1'b1, 8'h7D, 9'h000);
      check({8'h0, busy_a}, 9'h000);
      for (int i = 0; i < 11; i++) begin
         pulse(ev_mon[i], ev_hs[i], ev_pol[i]);
         check({8'h0, summary[ev_sum[i]]}, {8'h0, ev_exp[i] != 8'h00});
         rd(1'b1, ev_code[i], {1'b1, ev_exp[i]});
         cyc(8);
         rd(1'b1, ev_code2[i], {1'b1, ev_exp2[i]});
         clr();
         check({5'h0, summary}, 9'h000);
      end
      @(posedge clk_in);
      uv_pin <= 1'h1;
      cyc(6);
      rd(1'b1, 8'h80, 9'h144);
      rd(1'b1, 8'h7C, 9'h110);
      @(posedge clk_in);
      uv_pin <= 1'h0;
      cyc(6);
      rd(1'b1, 8'h80, 9'h104);
      clr();
      @(posedge clk_in);
      ov_pin <= 1'h1;
      cyc(6);
      rd(1'b1, 8'h80, 9'h126);
      rd(1'b1, 8'h7C, 9'h180);
      @(posedge clk_in);
      ov_pin <= 1'h0;
      cyc(6);
      clr();
      rd(1'b1, 8'h80, 9'h100);
      pulse(7'h40, 3'h0, 1'h1);
      check({8'h0, summary_ns[3]}, 9'h000);
      rd(1'b0, 8'h7A, 9'h000);
      rd(1'b1, 8'h7A, 9'h140);
      final_report();
   end
endmodule : pmbus_status_registers_test
